// [src/dma_launch_check.sv]
`timescale 1ns/1ps
// launch-time validation of pointer, count and endpoint
module dma_launch_check
    import usb_dma_pkg::*;
(
    input  wire logic [13:0] base_i,
    input  wire logic [6:0]  count_i,
    input  wire logic [2:0]  eps_i,
    output logic             ok_o
);

    logic [14:0] last_addr;   // address of the final byte
    logic        ok_ep;       // endpoint code allowed
    logic        ok_cnt;      // count nonzero and fits endpoint
    logic        ok_base;     // base inside window
    logic        ok_end;      // last byte inside window

    ////////////////////////////////////////////////////////////////////////////////
    // checks run before any byte moves
    assign ok_ep     = (eps_i <= EPS_MAX);
    assign ok_cnt    = (count_i != 7'h00) &&
                       ({1'b0, count_i} <= ep_limit(eps_i));
    assign ok_base   = ({1'b0, base_i} >= WIN_LO) && ({1'b0, base_i} <= WIN_HI);
    assign last_addr = 15'({1'b0, base_i} + {8'h00, count_i} - 15'h0001);
    assign ok_end    = (last_addr <= WIN_HI);
    assign ok_o      = ok_ep && ok_cnt && ok_base && ok_end;

endmodule

// [src/dma_mover.sv]
`timescale 1ns/1ps
// byte mover: one read per cycle, write follows two cycles behind
module dma_mover
    import usb_dma_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        start_i,      // one-cycle launch
    input  wire logic        dir_i,        // 1: ram to endpoint
    input  wire logic [2:0]  eps_i,
    input  wire logic [13:0] base_i,
    input  wire logic [6:0]  count_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [2:0]       ep_o,
    output logic [13:0]      ram_raddr_o,
    output logic             ram_re_o,
    input  wire logic [7:0]  ram_rdata_i,
    output logic [13:0]      ram_waddr_o,
    output logic             ram_we_o,
    output logic [7:0]       ram_wdata_o,
    output logic [6:0]       epb_ridx_o,
    output logic             epb_re_o,
    input  wire logic [7:0]  epb_rdata_i,
    output logic [6:0]       epb_widx_o,
    output logic             epb_we_o,
    output logic [7:0]       epb_wdata_o
);

    logic        dir_r;       // latched direction
    logic [13:0] base_r;      // latched base pointer
    logic [6:0]  cnt_r;       // latched count
    logic [6:0]  rd_left_r;   // reads still to issue
    logic [6:0]  rd_off_r;    // next read offset
    logic [6:0]  wr_off_r;    // next write offset
    logic        pend_r;      // read strobe is out this cycle
    logic        cap_r;       // returned byte sits on the data input
    logic        rd_go;       // issue a read this edge
    logic        last_wr;     // this capture is the final byte

    assign rd_go   = busy_o && (rd_left_r != 7'h00);
    assign last_wr = cap_r && (7'(wr_off_r + 7'h01) == cnt_r);

    ////////////////////////////////////////////////////////////////////////////////
    // read side: first read leaves with the launch itself
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dir_r <= 1'b0;
            base_r <= PTR_RST;
            cnt_r <= CNT_RST;
            ep_o <= EPS_RST;
            rd_left_r <= 7'h00;
            rd_off_r <= 7'h00;
            ram_raddr_o <= 14'h0000;
            epb_ridx_o <= 7'h00;
            ram_re_o <= 1'b0;
            epb_re_o <= 1'b0;
            pend_r <= 1'b0;
        end else if (start_i) begin
            // byte zero at the base pointer
            dir_r <= dir_i;
            base_r <= base_i;
            cnt_r <= count_i;
            ep_o <= eps_i;
            rd_left_r <= 7'(count_i - 7'h01);
            rd_off_r <= 7'h01;
            ram_raddr_o <= base_i;
            epb_ridx_o <= 7'h00;
            ram_re_o <= dir_i;
            epb_re_o <= !dir_i;
            pend_r <= 1'b1;
        end else begin
            // ascending addresses, one per cycle
            ram_raddr_o <= 14'(base_r + {7'h00, rd_off_r});
            epb_ridx_o <= rd_off_r;
            ram_re_o <= rd_go && dir_r;
            epb_re_o <= rd_go && !dir_r;
            pend_r <= rd_go;
            if (rd_go) begin
                rd_left_r <= 7'(rd_left_r - 7'h01);
                rd_off_r <= 7'(rd_off_r + 7'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write side: capture returned byte, write it next cycle
    // memories answer one cycle after the strobe, so capture trails it by one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_r <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            wr_off_r <= 7'h00;
            ram_waddr_o <= 14'h0000;
            epb_widx_o <= 7'h00;
            ram_we_o <= 1'b0;
            epb_we_o <= 1'b0;
            ram_wdata_o <= 8'h00;
            epb_wdata_o <= 8'h00;
        end else begin
            cap_r <= pend_r;
            ram_we_o <= cap_r && !dir_r;
            epb_we_o <= cap_r && dir_r;
            ram_wdata_o <= epb_rdata_i;
            epb_wdata_o <= ram_rdata_i;
            ram_waddr_o <= 14'(base_r + {7'h00, wr_off_r});
            epb_widx_o <= wr_off_r;
            done_o <= last_wr;
            if (start_i) begin
                busy_o <= 1'b1;
                wr_off_r <= 7'h00;
            end else if (cap_r) begin
                wr_off_r <= 7'(wr_off_r + 7'h01);
                if (last_wr) begin
                    busy_o <= 1'b0;
                end
            end
        end
    end

endmodule

// [src/usb_dma_pkg.sv]
// Behaviour
// - three-bit endpoint select picks endpoint zero..seven
// - byte limit per endpoint: 64, 128, 8
// - zero count or endpoint above four is violation
// - valid launch clears the error flag
// - software clears error flag by writing zero
// - bad base, overrun or oversize sets error
// - window checked against 0x0100 through 0x10ff
// - set error flag raises the usb interrupt
// - failed launch leaves pointer and count unchanged
// - direction zero endpoint to ram, one reverse
// - written endpoint data never read back here
// - software sets run, hardware clears it
// - processor stalls for whole transfer, then resumes
// - running transfer cannot be interrupted
// - fourteen-bit pointer, high register top bits zero
// - pointer resets to 0x0100
// - pointer is source sending, destination receiving
// - pointer ends at last address plus one
// - seven-bit count kept after transfer, top zero
// - n bytes finish within n plus one cycles
// - registers inaccessible while usb is disabled
package usb_dma_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register indexes, byte address is four times the index
    localparam logic [7:0]  CS_IDX       = 8'hea;   // transfer_control_status
    localparam logic [7:0]  PL_IDX       = 8'heb;   // ram_pointer_low
    localparam logic [7:0]  PH_IDX       = 8'hec;   // ram_pointer_high
    localparam logic [7:0]  BC_IDX       = 8'hed;   // transfer_byte_count

    ////////////////////////////////////////////////////////////////////////////////
    // control/status field positions
    localparam int          RUN_BIT      = 0;       // run_bit
    localparam int          DIR_BIT      = 1;       // transfer_direction
    localparam int          ERR_BIT      = 2;       // transfer_error_bit
    localparam int          EPS_LO       = 4;       // endpoint_select low bit
    localparam int          EPS_HI       = 6;       // endpoint_select high bit

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [13:0] PTR_RST      = 14'h0100;
    localparam logic [6:0]  CNT_RST      = 7'h00;
    localparam logic [2:0]  EPS_RST      = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // allowed ram window and endpoint limits
    localparam logic [14:0] WIN_LO       = 15'h0100;
    localparam logic [14:0] WIN_HI       = 15'h10ff;
    localparam logic [2:0]  EPS_MAX      = 3'h4;
    localparam logic [7:0]  EP0_SIZE     = 8'h40;   // single 64-byte bank
    localparam logic [7:0]  EP_DBL_SIZE  = 8'h80;   // two 64-byte banks
    localparam logic [7:0]  EP_SML_SIZE  = 8'h08;   // 8-byte endpoints

    // largest byte count the selected endpoint holds
    function automatic logic [7:0] ep_limit(input logic [2:0] eps);
        logic [7:0] lim;
        lim = EP_SML_SIZE;
        if (eps == 3'h0) begin
            lim = EP0_SIZE;
        end else if (eps <= 3'h3) begin
            lim = EP_DBL_SIZE;
        end
        return lim;
    endfunction

endpackage

// [src/usb_endpoint_ram_dma.sv]
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
// endpoint copy engine: wishbone registers, launch check, mover
module usb_endpoint_ram_dma
    import usb_dma_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    // wishbone classic slave
    input  wire logic [9:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        WE_I,
    input  wire logic        STB_I,
    input  wire logic        CYC_I,
    output logic             ACK_O,
    // module state
    input  wire logic        USB_EN_I,
    output logic             CPU_STALL_O,
    output logic             USB_IRQ_O,
    output logic             DONE_O,
    // system ram port
    output logic [13:0]      RAM_RADDR_O,
    output logic             RAM_RE_O,
    input  wire logic [7:0]  RAM_RDATA_I,
    output logic [13:0]      RAM_WADDR_O,
    output logic             RAM_WE_O,
    output logic [7:0]       RAM_WDATA_O,
    // endpoint_buffer_ram port
    output logic [2:0]       EPB_SEL_O,
    output logic [6:0]       EPB_RIDX_O,
    output logic             EPB_RE_O,
    input  wire logic [7:0]  EPB_RDATA_I,
    output logic [6:0]       EPB_WIDX_O,
    output logic             EPB_WE_O,
    output logic [7:0]       EPB_WDATA_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [13:0] ptr_r;          // ram_base_pointer
    logic [6:0]  cnt_r;          // transfer_byte_count
    logic [2:0]  eps_r;          // endpoint_select
    logic        dir_r;          // transfer_direction
    logic        err_r;          // transfer_error_flag
    logic        ack_r;          // bus acknowledge
    logic [31:0] dat_r;          // bus read data
    logic        irq_r;          // usb interrupt request

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [7:0]  idx;            // word index
    logic        busy;           // transfer in progress
    logic        done;           // last byte written
    logic        take;           // request accepted this edge
    logic        wr_lane;        // write carrying low byte
    logic        wr_cs;          // write to control/status
    logic        wr_pl;          // write to pointer low
    logic        wr_ph;          // write to pointer high
    logic        wr_bc;          // write to byte count
    logic        launch;         // run bit written
    logic        chk_ok;         // launch checks pass
    logic        start;          // transfer begins
    logic        fail;           // launch rejected
    logic        sw_clr;         // software clears error
    logic [7:0]  cs_val;         // control/status read view
    logic [7:0]  rd_mux;         // selected read byte

    assign idx     = ADR_I[9:2];
    // no answer while a transfer runs; the stalled processor never asks
    assign take    = CYC_I && STB_I && !ack_r && !busy;
    // disabled module: answered, writes dropped, reads zero
    assign wr_lane = take && WE_I && SEL_I[0] && USB_EN_I;
    assign wr_cs   = wr_lane && (idx == CS_IDX);
    assign wr_pl   = wr_lane && (idx == PL_IDX);
    assign wr_ph   = wr_lane && (idx == PH_IDX);
    assign wr_bc   = wr_lane && (idx == BC_IDX);
    assign launch  = wr_cs && DAT_I[RUN_BIT];
    assign start   = launch && chk_ok;
    assign fail    = launch && !chk_ok;
    assign sw_clr  = wr_cs && !DAT_I[ERR_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // launch checks stored pointer and count with the endpoint written in the same access
    dma_launch_check u_check (
        .base_i  (ptr_r),
        .count_i (cnt_r),
        .eps_i   (DAT_I[EPS_HI:EPS_LO]),
        .ok_o    (chk_ok)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read view; reserved bits zero
    assign cs_val = {1'b0, eps_r, 1'b0, err_r, dir_r, busy};
    assign rd_mux = !USB_EN_I         ? 8'h00 :
                    (idx == CS_IDX)   ? cs_val :
                    (idx == PL_IDX)   ? ptr_r[7:0] :
                    (idx == PH_IDX)   ? {2'b00, ptr_r[13:8]} :
                    (idx == BC_IDX)   ? {1'b0, cnt_r} :
                    8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait-free answer, ack drops next cycle
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= take;
            if (take) begin
                dat_r <= {24'h00_0000, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control fields
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            eps_r <= EPS_RST;
            dir_r <= 1'b0;
        end else if (wr_cs) begin
            eps_r <= DAT_I[EPS_HI:EPS_LO];
            dir_r <= DAT_I[DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error flag: launch result beats the software clear
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            err_r <= 1'b0;
        end else if (fail) begin
            err_r <= 1'b1;
        end else if (start) begin
            err_r <= 1'b0;
        end else if (sw_clr) begin
            err_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt follows the flag while it stays set
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= err_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pointer: software load, advance by count at launch
    // the mover keeps its own base copy and the bus is refused until the
    // last byte is captured, so software only ever sees the advanced value
    // after completion; a done-time update would race the first access
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr_r <= PTR_RST;
        end else if (start) begin
            ptr_r <= 14'(ptr_r + {7'h00, cnt_r});
        end else if (wr_pl) begin
            ptr_r[7:0] <= DAT_I[7:0];
        end else if (wr_ph) begin
            ptr_r[13:8] <= DAT_I[5:0];
        end
    end
    // a rejected launch writes neither pointer nor count

    ////////////////////////////////////////////////////////////////////////////////
    // byte count, never altered by a transfer
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cnt_r <= CNT_RST;
        end else if (wr_bc) begin
            cnt_r <= DAT_I[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mover; its busy flop is the run bit and the stall
    dma_mover u_mover (
        .clk_i       (MCLK_I),
        .rstn_i      (RSTN_I),
        .start_i     (start),
        .dir_i       (DAT_I[DIR_BIT]),
        .eps_i       (DAT_I[EPS_HI:EPS_LO]),
        .base_i      (ptr_r),
        .count_i     (cnt_r),
        .busy_o      (busy),
        .done_o      (done),
        .ep_o        (EPB_SEL_O),
        .ram_raddr_o (RAM_RADDR_O),
        .ram_re_o    (RAM_RE_O),
        .ram_rdata_i (RAM_RDATA_I),
        .ram_waddr_o (RAM_WADDR_O),
        .ram_we_o    (RAM_WE_O),
        .ram_wdata_o (RAM_WDATA_O),
        .epb_ridx_o  (EPB_RIDX_O),
        .epb_re_o    (EPB_RE_O),
        .epb_rdata_i (EPB_RDATA_I),
        .epb_widx_o  (EPB_WIDX_O),
        .epb_we_o    (EPB_WE_O),
        .epb_wdata_o (EPB_WDATA_O)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign ACK_O       = ack_r;
    assign DAT_O       = dat_r;
    assign USB_IRQ_O   = irq_r;
    assign DONE_O      = done;
    assign CPU_STALL_O = busy;

endmodule

// [test/dma_mem_model.sv]
`timescale 1ns/1ps
// system ram and endpoint buffer, synchronous, one cycle read latency
module dma_mem_model (
    input  wire logic        clk_i,
    input  wire logic [13:0] raddr_i,
    input  wire logic        re_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [13:0] waddr_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic [6:0]  ridx_i,
    input  wire logic        bre_i,
    output logic      [7:0]  brdata_o,
    input  wire logic [6:0]  widx_i,
    input  wire logic        bwe_i,
    input  wire logic [7:0]  bwdata_i
);
    logic [7:0] ram [16384];  // byte-wide system ram
    logic [7:0] epb [1024];   // eight endpoints of 128 bytes
    // known fill patterns
    initial begin
        for (int i = 0; i < 16384; i++) ram[i] = 8'(i) ^ 8'(i >> 8) ^ 8'ha5;
        for (int i = 0; i < 1024; i++) epb[i] = 8'(i) + 8'h33;
        rdata_o = 8'h00;
        brdata_o = 8'h00;
    end
    // idle data toggles so a stale byte never looks valid
    always @(posedge clk_i) begin
        rdata_o <= re_i ? ram[raddr_i] : ~rdata_o;
        brdata_o <= bre_i ? epb[{sel_i, ridx_i}] : ~brdata_o;
        if (we_i) ram[waddr_i] <= wdata_i;
        if (bwe_i) epb[{sel_i, widx_i}] <= bwdata_i;
    end
endmodule

// [test/usb_endpoint_ram_dma_checker.sv]
`timescale 1ns/1ps
// watches bus answers, stall and memory strobes of the copy engine
module usb_endpoint_ram_dma_checker (
    input wire logic        MCLK_I,
    input wire logic        RSTN_I,
    input wire logic        WE_I,
    input wire logic        USB_EN_I,
    input wire logic        ACK_O,
    input wire logic [31:0] DAT_O,
    input wire logic        CPU_STALL_O,
    input wire logic        USB_IRQ_O,
    input wire logic        DONE_O,
    input wire logic [13:0] RAM_RADDR_O,
    input wire logic        RAM_RE_O,
    input wire logic [13:0] RAM_WADDR_O,
    input wire logic        RAM_WE_O,
    input wire logic        EPB_RE_O,
    input wire logic [6:0]  EPB_WIDX_O,
    input wire logic        EPB_WE_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    ////////////////////////////////////////
    a_ack_in_run: assert property (CPU_STALL_O && $past(CPU_STALL_O) |-> !ACK_O)
        else $error("bus answered during a transfer");
    a_irq_after_ack: assert property ($rose(USB_IRQ_O) |-> $past(ACK_O))
        else $error("irq rose without a launch");
    a_done_ends_run: assert property (DONE_O |-> $fell(CPU_STALL_O))
        else $error("done without end of stall");
    a_run_bounded: assert property ($rose(CPU_STALL_O) |-> ##[1:129] !CPU_STALL_O)
        else $error("transfer ran too long");
    a_strobe_stalls: assert property (RAM_RE_O || EPB_RE_O |-> CPU_STALL_O)
        else $error("read strobe outside a stall");
    a_one_way: assert property (RAM_RE_O |-> !EPB_RE_O && !RAM_WE_O)
        else $error("both directions active");
    a_no_readback: assert property (EPB_WE_O |-> !EPB_RE_O && !RAM_WE_O)
        else $error("buffer read while emitting");
    a_raddr_step: assert property (RAM_RE_O && $past(RAM_RE_O)
        |-> RAM_RADDR_O == $past(RAM_RADDR_O) + 14'h1)
        else $error("ram read address not ascending");
    a_waddr_step: assert property (RAM_WE_O && $past(RAM_WE_O)
        |-> RAM_WADDR_O == $past(RAM_WADDR_O) + 14'h1)
        else $error("ram write address not ascending");
    a_widx_step: assert property (EPB_WE_O && $past(EPB_WE_O)
        |-> EPB_WIDX_O == $past(EPB_WIDX_O) + 7'h1)
        else $error("buffer index not ascending");
    a_ram_window: assert property (RAM_RE_O |-> RAM_RADDR_O inside {[14'h0100:14'h10ff]})
        else $error("ram read outside window");
    a_off_reads_zero: assert property (ACK_O && !WE_I && !USB_EN_I |-> DAT_O == 32'h0)
        else $error("register visible while disabled");
endmodule

// [test/usb_endpoint_ram_dma_tb.sv]
`timescale 1ns/1ps
// wishbone-driven bench for the endpoint copy engine
module usb_endpoint_ram_dma_tb;
    import usb_dma_pkg::*;
    logic        mclk = 1'b0, rstn = 1'b0, we = 1'b0, stb = 1'b0, cyc = 1'b0, usb_en = 1'b1;
    logic [9:0]  adr = 10'h0;
    logic [31:0] dat_w = 32'h0, dat_r, q;
    logic [3:0]  sel = 4'h0;
    logic        ack, stall, irq, done, ram_re, ram_we, epb_re, epb_we;
    logic [13:0] ram_raddr, ram_waddr;
    logic [7:0]  ram_rdata, ram_wdata, epb_rdata, epb_wdata;
    logic [2:0]  epb_sel;
    logic [6:0]  epb_ridx, epb_widx;
    int          errors = 0, checked = 0, stall_cnt = 0;
    // failing launches: pointer, count, control
    logic [13:0] eptr [6] = '{14'h0100, 14'h0100, 14'h0100, 14'h0100, 14'h00ff, 14'h10fa};
    logic [6:0]  ecnt [6] = '{7'd0, 7'd1, 7'd9, 7'd65, 7'd1, 7'd8};
    logic [7:0]  ecs  [6] = '{8'h03, 8'h53, 8'h43, 8'h03, 8'h01, 8'h03};

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (stall === 1'b1) stall_cnt++;

    usb_endpoint_ram_dma u_usb_endpoint_ram_dma (.MCLK_I(mclk), .RSTN_I(rstn), .ADR_I(adr),
        .DAT_I(dat_w), .DAT_O(dat_r), .SEL_I(sel), .WE_I(we), .STB_I(stb), .CYC_I(cyc),
        .ACK_O(ack), .USB_EN_I(usb_en), .CPU_STALL_O(stall), .USB_IRQ_O(irq), .DONE_O(done),
        .RAM_RADDR_O(ram_raddr), .RAM_RE_O(ram_re), .RAM_RDATA_I(ram_rdata),
        .RAM_WADDR_O(ram_waddr), .RAM_WE_O(ram_we), .RAM_WDATA_O(ram_wdata),
        .EPB_SEL_O(epb_sel), .EPB_RIDX_O(epb_ridx), .EPB_RE_O(epb_re), .EPB_RDATA_I(epb_rdata),
        .EPB_WIDX_O(epb_widx), .EPB_WE_O(epb_we), .EPB_WDATA_O(epb_wdata));
    dma_mem_model u_mem (.clk_i(mclk), .raddr_i(ram_raddr), .re_i(ram_re), .rdata_o(ram_rdata),
        .waddr_i(ram_waddr), .we_i(ram_we), .wdata_i(ram_wdata), .sel_i(epb_sel),
        .ridx_i(epb_ridx), .bre_i(epb_re), .brdata_o(epb_rdata), .widx_i(epb_widx),
        .bwe_i(epb_we), .bwdata_i(epb_wdata));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00};
        dat_w <= {24'h0, d}; sel <= 4'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 300);
        if (n >= 300) begin
            errors++;
            finish_test();
        end
        q = dat_r;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(q, exp);
    endtask
    // load pointer and count, launch, then wait out the stall with a read
    task automatic launch(input logic [13:0] p, input logic [6:0] n, input logic [7:0] cs);
        wr(PH_IDX, {2'b00, p[13:8]});
        wr(PL_IDX, p[7:0]);
        wr(BC_IDX, {1'b0, n});
        stall_cnt = 0;
        wr(CS_IDX, cs);
        bus(PL_IDX, 1'b0, 8'h00);
    endtask
    function automatic logic [7:0] rpat(input int a);
        return 8'(a) ^ 8'(a >> 8) ^ 8'ha5;
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdc(CS_IDX, 32'h00);
        rdc(PL_IDX, 32'h00);
        rdc(PH_IDX, 32'h01);
        rdc(BC_IDX, 32'h00);
        rdc(8'h10, 32'h00);
        wr(PH_IDX, 8'hff);
        rdc(PH_IDX, 32'h3f);
        wr(BC_IDX, 8'hff);
        rdc(BC_IDX, 32'h7f);
        for (int e = 0; e < 8; e++) begin
            wr(CS_IDX, {1'b0, 3'(e), 4'h0});
            rdc(CS_IDX, {25'h0, 3'(e), 4'h0});
        end
        // emission of eight bytes to endpoint one
        launch(14'h0100, 7'd8, 8'h13);
        check(stall_cnt, 32'd9);
        check(q, 32'h08);
        rdc(BC_IDX, 32'h08);
        rdc(CS_IDX, 32'h12);
        for (int i = 0; i < 8; i++) check(u_mem.epb[128 + i], rpat(256 + i));
        // reception from endpoint four, pointer reloaded with its updated value 0x0108
        launch(14'h0108, 7'd8, 8'h41);
        check(q, 32'h10);
        for (int i = 0; i < 8; i++) check(u_mem.ram[264 + i], 8'(i) + 8'h33);
        // refused launches
        for (int k = 0; k < 6; k++) begin
            launch(eptr[k], ecnt[k], ecs[k]);
            check(stall_cnt, 32'd0);
            check({31'h0, irq}, 32'h1);
            rdc(CS_IDX, (ecs[k] & 8'h72) | 8'h04);
            rdc(PL_IDX, eptr[k][7:0]);
            rdc(BC_IDX, ecnt[k]);
            wr(CS_IDX, ecs[k] & 8'h70);
            rdc(CS_IDX, ecs[k] & 8'h70);
            check({31'h0, irq}, 32'h0);
        end
        // a valid launch at the top of the window clears a standing error
        launch(14'h0100, 7'd0, 8'h03);
        launch(14'h10ff, 7'd1, 8'h03);
        check(q, 32'h00);
        rdc(CS_IDX, 32'h02);
        // registers vanish while the module is disabled
        usb_en <= 1'b0;
        wr(PH_IDX, 8'h05);
        rdc(PH_IDX, 32'h00);
        usb_en <= 1'b1;
        rdc(PH_IDX, 32'h11);
        finish_test();
    end
    // watchdog
    initial begin
        #300000;
        errors++;
        finish_test();
    end
endmodule

bind usb_endpoint_ram_dma usb_endpoint_ram_dma_checker u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
    .WE_I(WE_I), .USB_EN_I(USB_EN_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .CPU_STALL_O(CPU_STALL_O),
    .USB_IRQ_O(USB_IRQ_O), .DONE_O(DONE_O), .RAM_RADDR_O(RAM_RADDR_O), .RAM_RE_O(RAM_RE_O),
    .RAM_WADDR_O(RAM_WADDR_O), .RAM_WE_O(RAM_WE_O), .EPB_RE_O(EPB_RE_O),
    .EPB_WIDX_O(EPB_WIDX_O), .EPB_WE_O(EPB_WE_O));
